// File: shared/fvp_pkg.sv
package fvp_pkg;

    // Bit 3 multiplier; when it is set, bit 2 abs A, bit 1 abs B, bit 0 negate
    typedef enum logic [3:0] {
        FVP_OP_ADD = 4'h0,
        FVP_OP_SUBAB = 4'h1,
        FVP_OP_SUBBA = 4'h2,
        FVP_OP_CMP = 4'h3,
        FVP_OP_MUL = 4'h8,
        FVP_OP_MULN = 4'h9,
        FVP_OP_MULAB = 4'ha,
        FVP_OP_MULNAB = 4'hb,
        FVP_OP_MULABS = 4'he,
        FVP_OP_MULNABS = 4'hf
    } fvp_op_t;

    typedef struct packed {
        fvp_op_t op;
        logic out_sel;   // 0 sum register, 1 product register
        logic half_ms;   // 1 upper half of the result
    } fvp_instr_t;

    typedef struct packed {
        logic res_byp;
        logic in_byp;
        logic pipe_en;
    } fvp_cfg_t;

    typedef struct packed {
        logic [63:0] res;
        logic [1:0] cmp;
    } fvp_calc_t;

    typedef struct packed {
        fvp_cfg_t cfg;
        logic [31:0] ra;
        logic [31:0] rb;
        fvp_instr_t i0;
        logic v0;
        logic [63:0] pipe_r;
        logic [1:0] pipe_cmp;
        fvp_instr_t i1;
        logic v1;
        logic [63:0] sum;
        logic [63:0] prod;
        logic [1:0] cmp2;
        fvp_instr_t i2;
        logic v2;
        logic [1:0] cmp_flags;
        logic [31:0] prdata;
    } fvp_state_t;

endpackage

// File: shared/fvp_regs.svh
`ifndef FVP_REGS_SVH
`define FVP_REGS_SVH

// Register byte offsets
`define FVP_CTRL_OFS 12'h000
`define FVP_STATUS_OFS 12'h004

// Control fields
`define FVP_CTRL_PIPE_BIT 0
`define FVP_CTRL_INBYP_BIT 1
`define FVP_CTRL_RESBYP_BIT 2
`define FVP_CTRL_W 3
`define FVP_CTRL_RST 3'h1

// Status fields
`define FVP_ST_EQ_BIT 0
`define FVP_ST_LT_BIT 1
`define FVP_ST_LVL_LSB 8
`define FVP_ST_BUSY_BIT 16

// Datapath and buffer sizes
`define FVP_DATA_W 32
`define FVP_FIFO_DEPTH 32
`define FVP_STAGES 3

`endif

// File: src/fvp_fifo.sv
`timescale 1ns/100ps
`include "fvp_regs.svh"

module fvp_fifo import fvp_pkg::*; #(
    parameter int WIDTH = `FVP_DATA_W,
    parameter int DEPTH = `FVP_FIFO_DEPTH
) (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic rst,
    // Fill side
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    // Drain side
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data,
    // Occupancy
    output logic [$clog2(DEPTH):0] level
);
    localparam int AW = $clog2(DEPTH);

    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [AW-1:0] wp;
        logic [AW-1:0] rp;
        logic [AW:0] cnt;
    } fvp_fifo_st_t;

    fvp_fifo_st_t q_q;
    fvp_fifo_st_t q_d;
    logic push;
    logic pop;

    assign in_ready = q_q.cnt != (AW+1)'(DEPTH);
    assign out_valid = q_q.cnt != '0;
    assign out_data = q_q.mem[q_q.rp];
    assign level = q_q.cnt;
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;

    always_comb begin
        q_d = q_q;
        if (push) begin
            q_d.mem[q_q.wp] = in_data;
            q_d.wp = q_q.wp + 1'b1;
        end
        if (pop) begin
            q_d.rp = q_q.rp + 1'b1;
        end
        case ({push, pop})
            2'b10: q_d.cnt = q_q.cnt + 1'b1;
            2'b01: q_d.cnt = q_q.cnt - 1'b1;
            default: q_d.cnt = q_q.cnt;
        endcase
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            q_q <= '0;
        end else begin
            q_q <= q_d;
        end
    end

endmodule

// File: src/fvp_vec_path.sv
`timescale 1ns/100ps
`include "fvp_regs.svh"

// What this block does
// - Vector add runs the ALU alone, one operand pair per clock into sum
// - Pipelined: result reaches sum register two clocks after loading
// - Vector multiply runs multiplier alone, one pair per clock to product
// - Multiplier offers negated and absolute-value product variants
// - Pipelined: N pairs loaded clocks 1..N give outputs on 3..N+2
// - Unpiped: N pairs loaded clocks 1..N give outputs on 2..N+1
// - Unpiped: each sum or product computed within one clock
// - Subtractions and compare share add timing and throughput
// - Compare gives two status bits first; controller waits for them
// - Two modes: internal pipeline registers enabled or combinational
// - 32-bit output bus carries upper or lower half of chosen result
// - Input, pipeline and result levels bypass independently; sum and product bypass together
module fvp_vec_path import fvp_pkg::*; (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic rst,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Operand stream
    input wire logic op_valid,
    output logic op_ready,
    input wire logic [31:0] first_input_bus,
    input wire logic [31:0] second_input_bus,
    input wire fvp_instr_t instr,
    // Result bus
    output logic [31:0] y_bus,
    output logic y_valid,
    // Compare status
    output logic [1:0] cmp_flags,
    output logic cmp_valid,
    // Buffered results
    output logic res_valid,
    input wire logic res_ready,
    output logic [31:0] res_data
);
    fvp_state_t q_q;
    fvp_state_t q_d;

    logic acc;
    logic [31:0] a0;
    logic [31:0] b0;
    fvp_instr_t i0v;
    logic v0v;
    fvp_calc_t c1;
    logic [63:0] r1;
    logic [1:0] cmp1;
    fvp_instr_t i1v;
    logic v1v;
    logic [63:0] sum_v;
    logic [63:0] prod_v;
    logic [1:0] cmp2v;
    fvp_instr_t i2v;
    logic v2v;
    logic [63:0] src;
    logic is_cmp2;
    logic apb_hit;
    logic fifo_in_ready;
    logic [$clog2(`FVP_FIFO_DEPTH):0] fifo_level;

    function automatic fvp_calc_t fvp_calc(input logic [31:0] a,
                                           input logic [31:0] b,
                                           input fvp_op_t op);
        fvp_calc_t r;
        logic [3:0] ob;
        logic [63:0] ax;
        logic [63:0] bx;
        logic [63:0] ma;
        logic [63:0] mb;
        logic [63:0] p;
        logic [32:0] s;
        r = '0;
        ob = op;
        ax = {{32{a[31]}}, a};
        bx = {{32{b[31]}}, b};
        ma = (ob[2] && a[31]) ? 64'h0 - ax : ax;
        mb = (ob[1] && b[31]) ? 64'h0 - bx : bx;
        p = ma * mb;
        case (op)
            FVP_OP_ADD: s = {a[31], a} + {b[31], b};
            FVP_OP_SUBAB: s = {a[31], a} - {b[31], b};
            FVP_OP_SUBBA: s = {b[31], b} - {a[31], a};
            default: s = '0;
        endcase
        if (ob[3]) begin
            r.res = ob[0] ? 64'h0 - p : p;
        end else begin
            r.res = {{31{s[32]}}, s};
        end
        r.cmp = {$signed(a) < $signed(b), a == b};
        return r;
    endfunction

    // Stall sources early so every operand in flight has a free slot
    assign op_ready = 32'(fifo_level) + `FVP_STAGES < `FVP_FIFO_DEPTH;
    assign acc = op_valid && op_ready;
    assign apb_hit = paddr == `FVP_CTRL_OFS || paddr == `FVP_STATUS_OFS;
    assign pready = 1'b1;
    assign pslverr = psel && penable && !apb_hit;
    assign prdata = q_q.prdata;

    always_comb begin
        q_d = q_q;
        // Input register level
        if (acc) begin
            q_d.ra = first_input_bus;
            q_d.rb = second_input_bus;
            q_d.i0 = instr;
        end
        q_d.v0 = acc;
        a0 = q_q.cfg.in_byp ? first_input_bus : q_q.ra;
        b0 = q_q.cfg.in_byp ? second_input_bus : q_q.rb;
        i0v = q_q.cfg.in_byp ? instr : q_q.i0;
        v0v = q_q.cfg.in_byp ? acc : q_q.v0;

        // Internal pipeline level
        c1 = fvp_calc(a0, b0, i0v.op);
        q_d.pipe_r = c1.res;
        q_d.pipe_cmp = c1.cmp;
        q_d.i1 = i0v;
        q_d.v1 = v0v;
        r1 = q_q.cfg.pipe_en ? q_q.pipe_r : c1.res;
        cmp1 = q_q.cfg.pipe_en ? q_q.pipe_cmp : c1.cmp;
        i1v = q_q.cfg.pipe_en ? q_q.i1 : i0v;
        v1v = q_q.cfg.pipe_en ? q_q.v1 : v0v;

        // Sum and product registers: each unit only touches its own
        if (v1v && i1v.op[3]) begin
            q_d.prod = r1;
        end
        if (v1v && !i1v.op[3] && i1v.op != FVP_OP_CMP) begin
            q_d.sum = r1;
        end
        q_d.cmp2 = cmp1;
        q_d.i2 = i1v;
        q_d.v2 = v1v;
        sum_v = q_q.cfg.res_byp ? q_d.sum : q_q.sum;
        prod_v = q_q.cfg.res_byp ? q_d.prod : q_q.prod;
        cmp2v = q_q.cfg.res_byp ? cmp1 : q_q.cmp2;
        i2v = q_q.cfg.res_byp ? i1v : q_q.i2;
        v2v = q_q.cfg.res_byp ? v1v : q_q.v2;

        // Output mux sees only sum and product, never the pipe stage
        src = i2v.out_sel ? prod_v : sum_v;
        is_cmp2 = i2v.op == FVP_OP_CMP;
        if (v2v && is_cmp2) begin
            q_d.cmp_flags = cmp2v;
        end

        // Register file
        if (psel && penable && pwrite && paddr == `FVP_CTRL_OFS) begin
            q_d.cfg = pwdata[`FVP_CTRL_W-1:0];
        end
        if (psel && !penable) begin
            q_d.prdata = '0;
            case (paddr)
                `FVP_CTRL_OFS: begin
                    q_d.prdata[`FVP_CTRL_W-1:0] = q_q.cfg;
                end
                `FVP_STATUS_OFS: begin
                    q_d.prdata[`FVP_ST_EQ_BIT] = q_q.cmp_flags[0];
                    q_d.prdata[`FVP_ST_LT_BIT] = q_q.cmp_flags[1];
                    q_d.prdata[`FVP_ST_LVL_LSB +: 6] = fifo_level;
                    q_d.prdata[`FVP_ST_BUSY_BIT] =
                        q_q.v0 || q_q.v1 || q_q.v2;
                end
                default: q_d.prdata = '0;
            endcase
        end
    end

    // Compare yields flags, no numeric word on the result bus
    assign y_bus = i2v.half_ms ? src[63:32] : src[31:0];
    assign y_valid = v2v && !is_cmp2;
    assign cmp_valid = v2v && is_cmp2;
    assign cmp_flags = cmp_valid ? cmp2v : q_q.cmp_flags;

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            q_q <= '0;
            q_q.cfg <= `FVP_CTRL_RST;
        end else begin
            q_q <= q_d;
        end
    end

    fvp_fifo #(
        .WIDTH(`FVP_DATA_W),
        .DEPTH(`FVP_FIFO_DEPTH)
    ) u_fifo (
        .sys_clk(sys_clk),
        .rst(rst),
        .in_valid(y_valid),
        .in_ready(fifo_in_ready),
        .in_data(y_bus),
        .out_valid(res_valid),
        .out_ready(res_ready),
        .out_data(res_data),
        .level(fifo_level)
    );

    // Checks
    logic piped;
    logic unpiped;
    logic [63:0] full_prod_w;
    logic [63:0] prod_cur;
    assign piped = q_q.cfg.pipe_en && !q_q.cfg.in_byp && !q_q.cfg.res_byp;
    assign unpiped = !q_q.cfg.pipe_en && !q_q.cfg.in_byp
        && !q_q.cfg.res_byp;
    assign full_prod_w = {{32{first_input_bus[31]}}, first_input_bus}
        * {{32{second_input_bus[31]}}, second_input_bus};
    assign prod_cur = q_q.prod;

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (rst);

    add_pipe_lat_a: assert property (
        acc && piped && instr.op == FVP_OP_ADD && !instr.out_sel
        && !instr.half_ms |-> ##3 (y_valid
        && y_bus == $past(first_input_bus + second_input_bus, 3)))
        else $error("pipelined add result late or wrong");

    pipe_stream_a: assert property (
        acc && piped |-> ##3
        (y_valid || cmp_valid))
        else $error("pipelined output not on third clock");

    unpiped_lat_a: assert property (
        acc && unpiped |-> ##2 (y_valid || cmp_valid))
        else $error("unpiped output not on second clock");

    mul_unpiped_a: assert property (
        acc && unpiped && instr.op == FVP_OP_MUL && instr.out_sel
        && !instr.half_ms |-> ##2 (y_valid
        && y_bus == $past(full_prod_w[31:0], 2)))
        else $error("unpiped product wrong");

    neg_prod_a: assert property (
        acc && unpiped && instr.op == FVP_OP_MULN
        |-> ##2 prod_cur == 64'h0 - $past(full_prod_w, 2))
        else $error("negated product wrong");

    sub_ba_a: assert property (
        acc && unpiped && instr.op == FVP_OP_SUBBA && !instr.out_sel
        && !instr.half_ms |-> ##2 (y_valid
        && y_bus == $past(second_input_bus - first_input_bus, 2)))
        else $error("reverse subtract wrong");

    cmp_status_a: assert property (
        acc && unpiped && instr.op == FVP_OP_CMP |-> ##2 (cmp_valid
        && !y_valid
        && cmp_flags[0] == $past(first_input_bus == second_input_bus, 2)))
        else $error("compare flags missing or wrong");

    half_ms_a: assert property (
        acc && unpiped && instr.op == FVP_OP_MUL && instr.out_sel
        && instr.half_ms |-> ##2 y_bus == $past(full_prod_w[63:32], 2))
        else $error("upper half select wrong");

    add_keeps_prod_a: assert property (
        acc && unpiped && instr.op == FVP_OP_ADD |-> ##2 $stable(prod_cur))
        else $error("add disturbed product register");

    in_bypass_a: assert property (
        acc && q_q.cfg.pipe_en && q_q.cfg.in_byp && !q_q.cfg.res_byp
        |-> ##2 (y_valid || cmp_valid))
        else $error("input bypass latency wrong");

    fifo_room_a: assert property (
        y_valid |-> fifo_in_ready)
        else $error("result dropped at full buffer");

    pipe_add_c: cover property (acc && piped && instr.op == FVP_OP_ADD);
    unpiped_mul_c: cover property (acc && unpiped && instr.op[3]);
    cmp_seen_c: cover property (cmp_valid);
    stall_c: cover property (op_valid && !op_ready);

endmodule

// File: tb/fvp_host_model.sv
`timescale 1ns/100ps

module fvp_host_model (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic rst,
    // Result drain
    input wire logic res_valid,
    output logic res_ready,
    input wire logic [31:0] res_data,
    // Bench control and view
    input wire logic hold,
    input wire logic fast,
    output logic got_valid,
    output logic [31:0] got_data
);
    logic [1:0] tick;

    // Slow mode takes one word in four, so the buffer backs up
    always_ff @(posedge sys_clk) begin
        tick <= rst ? 2'h0 : tick + 2'h1;
        res_ready <= !rst && !hold && (fast || tick == 2'h3);
        got_valid <= !rst && res_valid && res_ready;
        got_data <= res_data;
    end
endmodule

// File: tb/tb_fvp_vec_path.sv
`timescale 1ns/100ps
`include "fvp_regs.svh"

module tb_fvp_vec_path import fvp_pkg::*; ;
    logic sys_clk = 0, rst = 1, psel = 0, penable = 0, pwrite = 0;
    logic op_valid = 0, hold = 0, fast = 1, refused = 0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, a_bus = 32'h0, b_bus = 32'h0;
    fvp_instr_t instr = fvp_instr_t'(6'h00);
    logic [31:0] prdata, y_bus, res_data, got_data;
    logic pready, pslverr, op_ready, y_valid, cmp_valid;
    logic res_valid, res_ready, got_valid;
    logic [1:0] cmp_flags, last_cmp = 2'h0;
    logic [32:0] e;
    int fail_count = 0, check_count = 0, cyc = 0, lat = 3, t;
    logic [32:0] exp_q[$];
    int acc_q[$];
    logic [31:0] fifo_q[$];
    fvp_op_t ops[10] = '{FVP_OP_ADD, FVP_OP_SUBAB, FVP_OP_SUBBA, FVP_OP_CMP,
        FVP_OP_MUL, FVP_OP_MULN, FVP_OP_MULAB, FVP_OP_MULNAB, FVP_OP_MULABS,
        FVP_OP_MULNABS};

    always #20 sys_clk = ~sys_clk;

    fvp_vec_path u_dut (.sys_clk(sys_clk), .rst(rst), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .op_valid(op_valid), .op_ready(op_ready), .first_input_bus(a_bus),
        .second_input_bus(b_bus), .instr(instr), .y_bus(y_bus),
        .y_valid(y_valid), .cmp_flags(cmp_flags), .cmp_valid(cmp_valid),
        .res_valid(res_valid), .res_ready(res_ready), .res_data(res_data));

    fvp_host_model u_host (.sys_clk(sys_clk), .rst(rst),
        .res_valid(res_valid), .res_ready(res_ready), .res_data(res_data),
        .hold(hold), .fast(fast), .got_valid(got_valid),
        .got_data(got_data));

    task automatic chk_word(input logic [31:0] got, exp, input string what);
        check_count++;
        if (got !== exp) begin
            fail_count++;
            $display("wrong value at %0t: %s %h not %h", $time, what, got, exp);
        end
    endtask

    task automatic chk_flags(input logic [1:0] got, exp, input string what);
        chk_word({30'h0, got}, {30'h0, exp}, what);
    endtask

    task automatic stop_test();
        $display("checks %0d mismatches %0d", check_count, fail_count);
        if (fail_count == 0 && check_count > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    // ALU results keep their carry and are sign-extended to 64 bits
    function automatic logic [32:0] ref_res(fvp_instr_t i,
                                            logic [31:0] a, b);
        logic signed [63:0] x, y, r;
        x = {{32{a[31]}}, a};
        y = {{32{b[31]}}, b};
        r = i.op == FVP_OP_SUBAB ? x - y
            : i.op == FVP_OP_SUBBA ? y - x : x + y;
        if (i.op == FVP_OP_CMP)
            return {31'h0, x < y, x == y} | 33'h100000000;
        if (i.op[3]) begin
            if (i.op[2] && x < 0) x = -x;
            if (i.op[1] && y < 0) y = -y;
            r = i.op[0] ? -(x * y) : x * y;
        end
        return {1'b0, i.half_ms ? r[63:32] : r[31:0]};
    endfunction

    task automatic apb(input logic w, input logic [11:0] a,
                       input logic [31:0] d, output logic [31:0] rd,
                       output logic err);
        @(posedge sys_clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge sys_clk);
        penable <= 1'b1;
        // Only the watchdog ends a wait for the answer
        do @(posedge sys_clk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic rd_chk(input logic [11:0] a, input logic [31:0] exp,
                          input logic eerr);
        logic [31:0] rd;
        logic err;
        apb(1'b0, a, 32'h0, rd, err);
        chk_word(rd, exp, "read data");
        chk_flags({1'b0, err}, {1'b0, eerr}, "slave error");
    endtask

    // Holds each pair until the edge that takes it
    task automatic send(input fvp_instr_t i, input int n);
        logic [31:0] a, b;
        logic r;
        repeat (n) begin
            a = $urandom;
            b = $urandom;
            op_valid <= 1'b1;
            a_bus <= a;
            b_bus <= b;
            instr <= i;
            exp_q.push_back(ref_res(i, a, b));
            r = 1'b0;
            for (int k = 0; k < 400 && r !== 1'b1; k++) begin
                @(negedge sys_clk) r = op_ready;
                if (r !== 1'b1) refused = 1'b1;
                @(posedge sys_clk);
            end
            if (r !== 1'b1) chk_word(32'h0, 32'h1, "pair never taken");
        end
    endtask

    task automatic quiet();
        op_valid <= 1'b0;
        @(posedge sys_clk);
        for (int k = 0; k < 800 && fifo_q.size() + exp_q.size() > 0; k++)
            @(posedge sys_clk);
        if (fifo_q.size() + exp_q.size() > 0)
            chk_word(32'h0, 32'h1, "results missing");
    endtask

    always @(posedge sys_clk) begin
        cyc++;
        if (!rst && op_valid && op_ready === 1'b1) acc_q.push_back(cyc);
        if (!rst && (y_valid === 1'b1 || cmp_valid === 1'b1)) begin
            if (acc_q.size() == 0 || exp_q.size() == 0) begin
                chk_word(32'h1, 32'h0, "result without operands");
            end else begin
                e = exp_q.pop_front();
                t = acc_q.pop_front();
                chk_word(32'(cyc - t), 32'(lat), "latency");
                if (e[32]) begin
                    chk_flags(cmp_flags, e[1:0], "flags");
                    last_cmp = e[1:0];
                end else begin
                    chk_word(y_bus, e[31:0], "y bus");
                    fifo_q.push_back(e[31:0]);
                end
            end
        end
        if (got_valid === 1'b1) chk_word(got_data, fifo_q.pop_front(), "drain");
    end

    initial begin
        logic [31:0] rd;
        logic err;
        rd = $urandom(86856);
        repeat (2) @(posedge sys_clk);
        rst <= 1'b0;
        rd_chk(`FVP_CTRL_OFS, 32'h1, 1'b0);
        rd_chk(`FVP_STATUS_OFS, 32'h0, 1'b0);
        rd_chk(12'h008, 32'h0, 1'b1);
        $display("test registers done");
        for (int c = 0; c < 8; c++) begin
            apb(1'b1, `FVP_CTRL_OFS, 32'(c), rd, err);
            lat = c[0] + !c[1] + !c[2];
            for (int k = 0; k < 10; k++)
                send('{op: ops[k], out_sel: ops[k][3],
                       half_ms: 1'($urandom)}, 1 + $urandom % 4);
            quiet();
            rd_chk(`FVP_STATUS_OFS, 32'(last_cmp), 1'b0);
            $display("test mode %0d done", c);
        end
        apb(1'b1, `FVP_CTRL_OFS, 32'h1, rd, err);
        lat = 3;
        hold <= 1'b1;
        fast <= 1'b0;
        fork
            send('{op: FVP_OP_ADD, out_sel: 1'b0, half_ms: 1'b0}, 40);
            begin
                for (int k = 0; k < 400 && !(refused && exp_q.size() == 1);
                     k++)
                    @(posedge sys_clk);
                chk_word(32'(fifo_q.size() >= 29), 32'h1, "refused early");
                rd_chk(`FVP_STATUS_OFS,
                       (32'(fifo_q.size()) << 8) | 32'(last_cmp), 1'b0);
                hold <= 1'b0;
            end
        join
        quiet();
        $display("test fill done");
        stop_test();
    end

    // Whole run needs well under a thousand cycles
    initial begin
        repeat (40000) @(posedge sys_clk);
        fail_count++;
        stop_test();
    end
endmodule
